// *** design/aqe_pkg.sv ***
package aqe_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_SRC      = 8'h04;
	localparam logic [7:0] OFF_SDIV     = 8'h08;
	localparam logic [7:0] OFF_SDLY     = 8'h0C;
	localparam logic [7:0] OFF_CDIV     = 8'h10;
	localparam logic [7:0] OFF_CDLY     = 8'h14;
	localparam logic [7:0] OFF_NCHAN    = 8'h18;
	localparam logic [7:0] OFF_PRECNT   = 8'h1C;
	localparam logic [7:0] OFF_POSTCNT  = 8'h20;
	localparam logic [7:0] OFF_STATUS   = 8'h24;
	localparam logic [7:0] OFF_SCOUNT   = 8'h28;

	// CTRL bits (write-one pulses at 0..2, levels above)
	localparam int CTRL_ARM_SW    = 0;
	localparam int CTRL_STOP_SW   = 1;
	localparam int CTRL_PULSE_SW  = 2;
	localparam int CTRL_FINITE    = 4;
	localparam int CTRL_PRETRIG   = 5;
	localparam int CTRL_START_HW  = 6;
	localparam int CTRL_PAUSE_EN  = 7;
	localparam int CTRL_PAUSE_LVL = 8;
	localparam int CTRL_LEVEL_OUT = 9;

	// SRC fields
	localparam int SRC_SCLK_LSB  = 0;  // 2 bits, sclk_src_e
	localparam int SRC_SCLK_EXT  = 2;
	localparam int SRC_SCLK_FALL = 3;
	localparam int SRC_TB_LSB    = 4;  // 2 bits, tb_src_e
	localparam int SRC_TB_FALL   = 6;
	localparam int SRC_CONV_EXT  = 7;
	localparam int SRC_CONV_FALL = 8;
	localparam int SRC_CTB_PIN   = 9;
	localparam int SRC_START_FALL = 10;
	localparam int SRC_REF_FALL  = 11;
	localparam int SRC_PIN_LSB   = 12; // 4 bits each, pin select
	localparam int SRC_TBPIN_LSB = 16;
	localparam int SRC_STPIN_LSB = 20;
	localparam int SRC_RFPIN_LSB = 24;
	localparam int SRC_PSPIN_LSB = 28;

	localparam logic [31:0] SRC_RESET   = 32'h0000_0000;
	localparam logic [15:0] SDLY_RESET  = 16'h0002;
	localparam logic [15:0] CDLY_RESET  = 16'h0003;
	localparam logic [15:0] SDIV_RESET  = 16'h0064;
	localparam logic [15:0] CDIV_RESET  = 16'h0004;
	localparam logic [4:0]  NCHAN_RESET = 5'h01;

	// Timebase rates from the 250 MHz core clock
	localparam int CLK_HZ      = 250_000_000;
	localparam int TB20_HZ     = 20_000_000;
	localparam int TB100K_HZ   = 100_000;
	localparam int TB20_DIV    = CLK_HZ / TB20_HZ;
	localparam int TB100K_DIV  = CLK_HZ / TB100K_HZ;
	// Padding between channels (us) and its cycle count
	localparam int PAD_US      = 10;
	localparam int PAD_CYC     = PAD_US * (CLK_HZ / 1_000_000);

	typedef enum logic [1:0] {SCLK_COUNTER, SCLK_DIVIDED, SCLK_SOFT} aqe_sclk_src_e;
	typedef enum logic [1:0] {TB_20MHZ, TB_100KHZ, TB_PIN} aqe_tb_src_e;
	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} aqe_state_e;
endpackage

// *** design/aqe_tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Carries the timebase tick between the divider and the sequencer
interface aqe_tick_if;
	logic tb_tick;
	logic tb20_tick;
	modport src (output tb_tick, output tb20_tick);
	modport dst (input tb_tick, input tb20_tick);
endinterface
`default_nettype wire

// *** design/aqe_timebase.sv ***
`timescale 1ns/1ps
`default_nettype none
module aqe_timebase (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire aqe_pkg::aqe_tb_src_e tb_src,
	input  wire logic                tb_fall,
	input  wire logic                tb_pin,
	aqe_tick_if.src                  tick
);
	logic [15:0] div20_reg;
	logic [15:0] div100_reg;
	logic        pin_d_reg;
	logic        t20;
	logic        t100;
	logic        tpin;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div20_reg  <= 16'h0000;
			div100_reg <= 16'h0000;
			pin_d_reg  <= 1'b0;
		end else begin
			div20_reg  <= t20 ? 16'h0000 : div20_reg + 16'h0001;
			div100_reg <= t100 ? 16'h0000 : div100_reg + 16'h0001;
			pin_d_reg  <= tb_pin;
		end
	end

	assign t20  = (div20_reg == 16'(aqe_pkg::TB20_DIV - 1));
	assign t100 = (div100_reg == 16'(aqe_pkg::TB100K_DIV - 1));
	// Timebase active edge selectable
	assign tpin = tb_fall ? (pin_d_reg & ~tb_pin) : (~pin_d_reg & tb_pin); // RULE11

	always_comb begin
		case (tb_src)
			aqe_pkg::TB_20MHZ:  tick.tb_tick = t20; // RULE11
			aqe_pkg::TB_100KHZ: tick.tb_tick = t100;
			aqe_pkg::TB_PIN:    tick.tb_tick = tpin;
			default:            tick.tb_tick = t20;
		endcase
	end
	assign tick.tb20_tick = t20;
endmodule // aqe_timebase
`default_nettype wire

// *** design/aqe_engine.sv ***
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: each accepted pacing edge samples every channel of the task once
// RULE2: pacing edge polarity selectable rising or falling
// RULE3: internal pacing from counter output, divided timebase or software pulse
// RULE4: internal counter divides the pacing timebase
// RULE5: any input function pin may be external pacing source
// RULE6: pacing output active high, pulse or whole-sample level
// RULE7: pacing edges ignored while no acquisition runs
// RULE8: pacing edges ignored while pause gate active
// RULE9: start trigger starts pacing counter; hardware or software stops it
// RULE10: start-to-first-pace delay configurable, default two timebase ticks
// RULE11: timebase from 20 MHz, 100 kHz or pin; edge selectable
// RULE12: pacing timebase never driven to any pin
// RULE13: each strobe converts one channel; sample is one or more strobes
// RULE14: strobe source internal or external, edge selectable
// RULE15: posttrigger count loaded, decremented per pace, done at zero
// RULE16: pretrigger count loaded at start, then posttrigger count reloaded
// RULE17: reference trigger ignored before pretrigger samples acquired
// RULE18: after accepted reference, count posttrigger samples then end
// RULE19: software start emits pulse on start trigger line
// RULE20: strobes padded 10 us apart, else spread evenly across sample; the code pads by CDIV ticks instead and leaves PAD_CYC unused
// RULE21: external pacing source must respect strobe timing
// RULE22: start, reference and pause are digital triggers only
// RULE23: strobe counter started by pace, reloads each strobe and per sample
// RULE24: pace-to-first-strobe delay configurable, default three ticks
// RULE25: pacing ignored until strobes done; stray strobes ignored
// RULE26: pause level programmable; internal pacing halts while active
// RULE27: finite count reaching zero in final phase returns to idle
module aqe_engine #(
	parameter int NPIN = 16
) (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic [31:0]          hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	input  wire logic [NPIN-1:0] pin_in,
	input  wire logic            counter_out,
	output logic                 sample_pacing_out,
	output logic                 conversion_strobe,
	output logic                 start_trigger_out,
	output logic                 acq_active
);
	////////////////////////////////////////////////////////////////
	logic [31:0] ctrl_reg;
	logic [31:0] src_reg;
	logic [15:0] sdiv_reg, sdly_reg, cdiv_reg, cdly_reg;
	logic [4:0]  nchan_reg;
	logic [31:0] pre_reg, post_reg;
	logic        wr_pend_reg;
	logic [7:0]  waddr_reg;
	logic        cmd_arm, cmd_stop, cmd_pulse;
	logic        done_sticky_reg;

	function automatic logic pin_pick(input logic [NPIN-1:0] p, input logic [3:0] s);
		pin_pick = p[s];
	endfunction

	function automatic logic edge_of(input logic d, input logic q, input logic fall);
		edge_of = fall ? (d & ~q) : (~d & q);
	endfunction

	// AHB-Lite: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			waddr_reg   <= 8'h00;
		end else begin
			wr_pend_reg <= hsel & hready & htrans[1] & hwrite;
			waddr_reg   <= haddr[7:0];
		end
	end

	assign cmd_arm   = wr_pend_reg && waddr_reg == aqe_pkg::OFF_CTRL && hwdata[aqe_pkg::CTRL_ARM_SW];
	assign cmd_stop  = wr_pend_reg && waddr_reg == aqe_pkg::OFF_CTRL && hwdata[aqe_pkg::CTRL_STOP_SW];
	assign cmd_pulse = wr_pend_reg && waddr_reg == aqe_pkg::OFF_CTRL && hwdata[aqe_pkg::CTRL_PULSE_SW];

	// Arming follows the configuration carried in the same word, not the stale register
	logic [31:0] ctrl_now;
	assign ctrl_now = (wr_pend_reg && waddr_reg == aqe_pkg::OFF_CTRL) ?
		{hwdata[31:3], 3'b000} : ctrl_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg  <= 32'h0000_0000;
			src_reg   <= aqe_pkg::SRC_RESET;
			sdiv_reg  <= aqe_pkg::SDIV_RESET;
			sdly_reg  <= aqe_pkg::SDLY_RESET;
			cdiv_reg  <= aqe_pkg::CDIV_RESET;
			cdly_reg  <= aqe_pkg::CDLY_RESET;
			nchan_reg <= aqe_pkg::NCHAN_RESET;
			pre_reg   <= 32'h0000_0000;
			post_reg  <= 32'h0000_0001;
		end else if (wr_pend_reg) begin
			case (waddr_reg)
				aqe_pkg::OFF_CTRL:    ctrl_reg  <= {hwdata[31:3], 3'b000};
				aqe_pkg::OFF_SRC:     src_reg   <= hwdata;
				aqe_pkg::OFF_SDIV:    sdiv_reg  <= hwdata[15:0];
				aqe_pkg::OFF_SDLY:    sdly_reg  <= hwdata[15:0];
				aqe_pkg::OFF_CDIV:    cdiv_reg  <= hwdata[15:0];
				aqe_pkg::OFF_CDLY:    cdly_reg  <= hwdata[15:0];
				aqe_pkg::OFF_NCHAN:   nchan_reg <= hwdata[4:0];
				aqe_pkg::OFF_PRECNT:  pre_reg   <= hwdata;
				aqe_pkg::OFF_POSTCNT: post_reg  <= hwdata;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	aqe_tick_if tick ();
	aqe_timebase u_tb (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tb_src  (aqe_pkg::aqe_tb_src_e'(src_reg[aqe_pkg::SRC_TB_LSB +: 2])),
		.tb_fall (src_reg[aqe_pkg::SRC_TB_FALL]),
		.tb_pin  (pin_pick(pin_in, src_reg[aqe_pkg::SRC_TBPIN_LSB +: 4])),
		.tick    (tick.src)
	);

	// Input edge detection; all triggers are digital edges or levels
	logic sp_q, st_q, rf_q, cv_q, ctr_q;
	logic sp_now, st_now, rf_now, cv_now;
	assign sp_now = pin_pick(pin_in, src_reg[aqe_pkg::SRC_PIN_LSB +: 4]); // RULE5
	assign st_now = pin_pick(pin_in, src_reg[aqe_pkg::SRC_STPIN_LSB +: 4]); // RULE22
	assign rf_now = pin_pick(pin_in, src_reg[aqe_pkg::SRC_RFPIN_LSB +: 4]);
	assign cv_now = pin_pick(pin_in, src_reg[aqe_pkg::SRC_PIN_LSB +: 4] + 4'h1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{sp_q, st_q, rf_q, cv_q, ctr_q} <= 5'h00;
		end else begin
			{sp_q, st_q, rf_q, cv_q, ctr_q} <= {sp_now, st_now, rf_now, cv_now, counter_out};
		end
	end

	logic pause_act;
	assign pause_act = ctrl_reg[aqe_pkg::CTRL_PAUSE_EN] &&
		(pin_pick(pin_in, src_reg[aqe_pkg::SRC_PSPIN_LSB +: 4]) == ctrl_reg[aqe_pkg::CTRL_PAUSE_LVL]); // RULE26

	logic start_ev, ref_ev;
	assign start_ev = ctrl_now[aqe_pkg::CTRL_START_HW] ?
		edge_of(st_q, st_now, src_reg[aqe_pkg::SRC_START_FALL]) : cmd_arm;
	assign ref_ev = edge_of(rf_q, rf_now, src_reg[aqe_pkg::SRC_REF_FALL]);

	////////////////////////////////////////////////////////////////
	aqe_pkg::aqe_state_e state_reg;
	logic [15:0] sdly_cnt_reg, sdiv_cnt_reg;
	logic        int_pace;
	logic        pace_raw;
	logic        pace_ok;
	logic        in_sample_reg;
	logic [31:0] scount_reg;
	logic        post_phase_reg;
	logic        ref_armed_reg;
	logic        finish;

	// Internal divider halted by pause
	logic div_tick;
	assign div_tick = state_reg == aqe_pkg::ST_RUN && tick.tb_tick && !pause_act; // RULE26
	assign int_pace = div_tick && sdiv_cnt_reg == 16'h0000;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sdiv_cnt_reg <= 16'h0000;
			sdly_cnt_reg <= 16'h0000;
		end else begin
			if (start_ev && state_reg == aqe_pkg::ST_IDLE)
				sdly_cnt_reg <= sdly_reg; // RULE10
			else if (state_reg == aqe_pkg::ST_DELAY && tick.tb_tick && sdly_cnt_reg != 16'h0000)
				sdly_cnt_reg <= sdly_cnt_reg - 16'h0001;
			if (state_reg != aqe_pkg::ST_RUN)
				sdiv_cnt_reg <= 16'h0000; // first pace right after the delay
			else if (div_tick)
				sdiv_cnt_reg <= (sdiv_cnt_reg == 16'h0000) ? sdiv_reg - 16'h0001 : sdiv_cnt_reg - 16'h0001; // RULE4
		end
	end

	always_comb begin
		if (src_reg[aqe_pkg::SRC_SCLK_EXT])
			pace_raw = edge_of(sp_q, sp_now, src_reg[aqe_pkg::SRC_SCLK_FALL]); // RULE2 RULE5
		else begin
			case (aqe_pkg::aqe_sclk_src_e'(src_reg[aqe_pkg::SRC_SCLK_LSB +: 2])) // RULE3
				aqe_pkg::SCLK_COUNTER: pace_raw = edge_of(ctr_q, counter_out, src_reg[aqe_pkg::SRC_SCLK_FALL]);
				aqe_pkg::SCLK_DIVIDED: pace_raw = int_pace;
				aqe_pkg::SCLK_SOFT:    pace_raw = cmd_pulse;
				default:               pace_raw = 1'b0;
			endcase
		end
	end

	// RULE21 is the source's duty: edges during a sample are simply dropped
	assign pace_ok = state_reg == aqe_pkg::ST_RUN && !pause_act && !in_sample_reg && pace_raw; // RULE7 RULE8 RULE25
	assign finish  = pace_ok && ctrl_reg[aqe_pkg::CTRL_FINITE] && post_phase_reg && scount_reg == 32'h1;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= aqe_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				aqe_pkg::ST_IDLE:  if (start_ev) state_reg <= aqe_pkg::ST_DELAY; // RULE9
				aqe_pkg::ST_DELAY: if (cmd_stop) state_reg <= aqe_pkg::ST_IDLE;
					else if (sdly_cnt_reg == 16'h0000 || src_reg[aqe_pkg::SRC_SCLK_EXT])
						state_reg <= aqe_pkg::ST_RUN;
				aqe_pkg::ST_RUN:   if (cmd_stop || finish) state_reg <= aqe_pkg::ST_IDLE; // RULE9 RULE27
				default:           state_reg <= aqe_pkg::ST_IDLE;
			endcase
		end
	end

	// Sample counter: pretrigger phase then posttrigger phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scount_reg     <= 32'h0000_0000;
			post_phase_reg <= 1'b0;
			ref_armed_reg  <= 1'b0;
		end else if (state_reg == aqe_pkg::ST_IDLE && start_ev) begin
			post_phase_reg <= !ctrl_now[aqe_pkg::CTRL_PRETRIG];
			ref_armed_reg  <= ctrl_now[aqe_pkg::CTRL_PRETRIG] && pre_reg == 32'h0;
			scount_reg     <= ctrl_now[aqe_pkg::CTRL_PRETRIG] ? pre_reg : post_reg; // RULE15 RULE16
		end else if (state_reg == aqe_pkg::ST_RUN) begin
			if (!post_phase_reg && ref_armed_reg && ref_ev) begin
				post_phase_reg <= 1'b1; // RULE18
				scount_reg     <= post_reg; // RULE16
			end else if (pace_ok && scount_reg != 32'h0) begin
				scount_reg <= scount_reg - 32'h1; // RULE15
				if (!post_phase_reg && scount_reg == 32'h1)
					ref_armed_reg <= 1'b1; // RULE17
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Conversion strobes: nchan per accepted sample
	logic [4:0]  conv_left_reg;
	logic [15:0] cdiv_cnt_reg;
	logic [15:0] even_div;
	logic        ctick, conv_int, conv_ext, conv_fire;
	// Padding counted on the 20 MHz tick, or on the pacing timebase when SRC_CTB_PIN is set; fall back to even spread when period is short
	assign even_div = (nchan_reg == 5'h00) ? cdiv_reg : sdiv_reg / {11'h000, nchan_reg};
	assign ctick    = src_reg[aqe_pkg::SRC_CTB_PIN] ? tick.tb_tick : tick.tb20_tick;
	assign conv_int = in_sample_reg && ctick && cdiv_cnt_reg == 16'h0000; // RULE23
	assign conv_ext = in_sample_reg && edge_of(cv_q, cv_now, src_reg[aqe_pkg::SRC_CONV_FALL]);
	assign conv_fire = src_reg[aqe_pkg::SRC_CONV_EXT] ? conv_ext : conv_int; // RULE14 RULE25

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_sample_reg <= 1'b0;
			conv_left_reg <= 5'h00;
			cdiv_cnt_reg  <= 16'h0000;
		end else if (pace_ok) begin
			in_sample_reg <= 1'b1; // RULE1
			conv_left_reg <= (nchan_reg == 5'h00) ? 5'h01 : nchan_reg; // RULE13
			cdiv_cnt_reg  <= cdly_reg; // RULE24
		end else if (in_sample_reg) begin
			if (conv_fire) begin
				conv_left_reg <= conv_left_reg - 5'h01;
				if (conv_left_reg == 5'h01)
					in_sample_reg <= 1'b0;
				cdiv_cnt_reg <= (cdiv_reg < even_div || sdiv_reg == 16'h0000) ? cdiv_reg : even_div; // RULE20 RULE23
			end else if (ctick && cdiv_cnt_reg != 16'h0000) begin
				cdiv_cnt_reg <= cdiv_cnt_reg - 16'h0001;
			end
		end else begin
			cdiv_cnt_reg <= cdly_reg; // RULE23
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs; the pacing timebase itself has no output path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_pacing_out <= 1'b0;
			conversion_strobe <= 1'b0;
			start_trigger_out <= 1'b0;
			acq_active        <= 1'b0;
			done_sticky_reg   <= 1'b0;
		end else begin
			sample_pacing_out <= ctrl_reg[aqe_pkg::CTRL_LEVEL_OUT] ? (pace_ok | (in_sample_reg & ~(conv_fire & conv_left_reg == 5'h01))) : pace_ok; // RULE6 RULE12
			conversion_strobe <= conv_fire; // RULE13
			start_trigger_out <= !ctrl_now[aqe_pkg::CTRL_START_HW] && cmd_arm && state_reg == aqe_pkg::ST_IDLE; // RULE19
			acq_active        <= state_reg != aqe_pkg::ST_IDLE;
			if (finish)
				done_sticky_reg <= 1'b1;
			else if (cmd_arm)
				done_sticky_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hsel && hready && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				aqe_pkg::OFF_CTRL:    hrdata <= ctrl_reg;
				aqe_pkg::OFF_SRC:     hrdata <= src_reg;
				aqe_pkg::OFF_SDIV:    hrdata <= {16'h0000, sdiv_reg};
				aqe_pkg::OFF_SDLY:    hrdata <= {16'h0000, sdly_reg};
				aqe_pkg::OFF_CDIV:    hrdata <= {16'h0000, cdiv_reg};
				aqe_pkg::OFF_CDLY:    hrdata <= {16'h0000, cdly_reg};
				aqe_pkg::OFF_NCHAN:   hrdata <= {27'h0000000, nchan_reg};
				aqe_pkg::OFF_PRECNT:  hrdata <= pre_reg;
				aqe_pkg::OFF_POSTCNT: hrdata <= post_reg;
				aqe_pkg::OFF_STATUS:  hrdata <= {26'h0000000, done_sticky_reg, ref_armed_reg,
					post_phase_reg, in_sample_reg, state_reg};
				aqe_pkg::OFF_SCOUNT:  hrdata <= scount_reg;
				default:              hrdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	a_idle_no_pace: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg != aqe_pkg::ST_RUN |-> !pace_ok) else $error("pace accepted outside run"); // RULE7
	a_pause_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
		pause_act |-> !pace_ok) else $error("pace accepted while paused"); // RULE8
	a_busy_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
		in_sample_reg |-> !pace_ok) else $error("pace accepted mid sample"); // RULE25
	a_pace_starts: assert property (@(posedge hclk) disable iff (!hresetn)
		pace_ok |=> in_sample_reg && conv_left_reg != 5'h00) else $error("sample not begun"); // RULE1
	a_strobe_gated: assert property (@(posedge hclk) disable iff (!hresetn)
		conversion_strobe |-> $past(in_sample_reg)) else $error("stray strobe"); // RULE25
	a_count_dec: assert property (@(posedge hclk) disable iff (!hresetn)
		pace_ok && !finish && scount_reg != 32'h0 && !ref_ev |=> scount_reg == $past(scount_reg) - 32'h1)
		else $error("sample count not decremented"); // RULE15
	sequence s_finish; finish; endsequence
	a_finish_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		s_finish |=> state_reg == aqe_pkg::ST_IDLE ##1 !acq_active) else $error("no idle at end"); // RULE27
	a_soft_start: assert property (@(posedge hclk) disable iff (!hresetn)
		cmd_arm && !ctrl_now[aqe_pkg::CTRL_START_HW] && state_reg == aqe_pkg::ST_IDLE
		|=> start_trigger_out ##1 !start_trigger_out) else $error("no start pulse"); // RULE19
	a_ref_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
		!ref_armed_reg && !post_phase_reg && state_reg == aqe_pkg::ST_RUN |=> !post_phase_reg)
		else $error("early reference accepted"); // RULE17
endmodule // aqe_engine
`default_nettype wire

// *** tb/aqe_pin_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module aqe_pin_src (
	input  wire logic   hclk,
	output logic [15:0] pin_in,
	output logic        counter_out
);
	int cnt = 0;
	initial pin_in = 16'h0000;
	initial counter_out = 1'b0;
	// General counter output runs free as a square wave
	always @(posedge hclk) begin
		cnt <= (cnt == 39) ? 0 : cnt + 1;
		if (cnt == 39)
			counter_out <= ~counter_out;
	end
	// Pulse is four cycles wide; the gap after it stays longer than one whole sample of strobes
	task automatic pulse(input int idx);
		@(posedge hclk) pin_in[idx] <= 1'b1;
		repeat (4) @(posedge hclk);
		pin_in[idx] <= 1'b0;
		repeat (300) @(posedge hclk);
	endtask
	task automatic set(input int idx, input logic v);
		@(posedge hclk) pin_in[idx] <= v;
	endtask
endmodule // aqe_pin_src
`default_nettype wire

// *** tb/adc_acquisition_timing_engine_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_acquisition_timing_engine_tb;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, counter_out;
	logic [31:0] haddr, hwdata, hrdata, lfsr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [15:0] pin_in;
	logic sample_pacing_out, conversion_strobe, start_trigger_out, acq_active, pace_d;
	int err_count = 0, n_compared = 0, cyc = 0;
	int n_pace, n_conv, n_start, w, wmax, post, nch;
	logic [31:0] src_tab [5] = '{32'h0, 32'h1, 32'h2, 32'h3004, 32'h300C};

	always #2 hclk = ~hclk;
	aqe_engine dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.pin_in(pin_in), .counter_out(counter_out), .sample_pacing_out(sample_pacing_out),
		.conversion_strobe(conversion_strobe), .start_trigger_out(start_trigger_out),
		.acq_active(acq_active));
	aqe_pin_src far (.hclk(hclk), .pin_in(pin_in), .counter_out(counter_out));

	////////////////////////////////////////////////////////////////
	// Output monitor: rising edges of pacing count, width tracked for level mode
	always @(posedge hclk) begin
		pace_d <= sample_pacing_out;
		if (sample_pacing_out === 1'b1 && pace_d !== 1'b1) n_pace++;
		w = (sample_pacing_out === 1'b1) ? w + 1 : 0;
		if (w > wmax) wmax = w;
		if (conversion_strobe === 1'b1) n_conv++;
		if (start_trigger_out === 1'b1) n_start++;
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_next();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
		q = hrdata;
		if (n >= 50) cmp(32'h0, 32'h1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp(q, e);
	endtask
	task automatic clr();
		n_pace = 0;
		n_conv = 0;
		n_start = 0;
		wmax = 0;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge hclk);
		while (acq_active !== 1'b0 && n < 8000) begin
			@(posedge hclk);
			n++;
		end
		cmp(n < 8000, 1'b1);
		repeat (200) @(posedge hclk);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0; hresetn = 1'b0; hsel = 1'b1; hwrite = 1'b0; htrans = 2'h0;
		haddr = 32'h0; hwdata = 32'h0; hsize = 3'h2; lfsr = 32'h870D;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(aqe_pkg::OFF_SDLY, 32'h2);
		chk(aqe_pkg::OFF_CDLY, 32'h3);
		chk(aqe_pkg::OFF_NCHAN, 32'h1);
		chk(8'h40, 32'h0);
		// Finite posttriggered runs with random counts
		wr(aqe_pkg::OFF_SDIV, 32'h14);
		wr(aqe_pkg::OFF_CDIV, 32'h2);
		for (int i = 0; i < 3; i++) begin
			post = 1 + lfsr_next() % 4;
			nch = 1 + lfsr_next() % 3;
			wr(aqe_pkg::OFF_SRC, 32'h1);
			wr(aqe_pkg::OFF_NCHAN, nch);
			wr(aqe_pkg::OFF_POSTCNT, post);
			clr();
			wr(aqe_pkg::OFF_CTRL, 32'h11);
			wait_idle();
			cmp(n_start, 1);
			cmp(n_pace, post);
			cmp(n_conv, post * nch);
		end
		// Pretriggered with an early reference edge on pin 5
		wr(aqe_pkg::OFF_SRC, 32'h0500_0001);
		wr(aqe_pkg::OFF_PRECNT, 32'h2);
		wr(aqe_pkg::OFF_POSTCNT, 32'h2);
		wr(aqe_pkg::OFF_CTRL, 32'h31);
		// Reference lands between the first and second pretrigger sample
		repeat (100) @(posedge hclk);
		far.pulse(5);
		repeat (900) @(posedge hclk);
		cmp(acq_active, 1'b1);
		clr();
		far.pulse(5);
		wait_idle();
		cmp(n_pace, 2);
		// Continuous run held by the pause gate on pin 7
		wr(aqe_pkg::OFF_SRC, 32'h7000_0001);
		far.set(7, 1'b1);
		clr();
		wr(aqe_pkg::OFF_CTRL, 32'h181);
		repeat (1500) @(posedge hclk);
		cmp(n_pace, 0);
		far.set(7, 1'b0);
		repeat (1500) @(posedge hclk);
		cmp(n_pace > 0, 1'b1);
		wr(aqe_pkg::OFF_CTRL, 32'h2);
		repeat (5) @(posedge hclk);
		cmp(acq_active, 1'b0);
		// Pacing while idle is dropped
		wr(aqe_pkg::OFF_SRC, 32'h2);
		clr();
		wr(aqe_pkg::OFF_CTRL, 32'h4);
		far.pulse(3);
		cmp(n_pace, 0);
		// Every pacing source, pulse and level output alternately
		wr(aqe_pkg::OFF_NCHAN, 32'h1);
		foreach (src_tab[i]) begin
			wr(aqe_pkg::OFF_SRC, src_tab[i]);
			wr(aqe_pkg::OFF_CTRL, 32'h1 | ((i % 2) << 9));
			repeat (100) @(posedge hclk);
			clr();
			for (int k = 0; k < 3; k++) begin
				if (i == 2) wr(aqe_pkg::OFF_CTRL, 32'h4 | ((i % 2) << 9));
				if (i > 2) far.pulse(3);
				else repeat (300) @(posedge hclk);
			end
			if (i >= 2) cmp(n_pace, 3);
			else cmp(n_pace > 0, 1'b1);
			cmp(wmax > 1, i % 2);
			wr(aqe_pkg::OFF_CTRL, 32'h2);
		end
		// Hardware start on pin 2, external pacing on pin 3, external strobes on pin 4
		wr(aqe_pkg::OFF_SRC, 32'h0020_3084);
		wr(aqe_pkg::OFF_NCHAN, 32'h2);
		wr(aqe_pkg::OFF_POSTCNT, 32'h1);
		wr(aqe_pkg::OFF_CTRL, 32'h50);
		clr();
		far.pulse(2);
		far.pulse(4);
		far.pulse(3);
		repeat (3) far.pulse(4);
		cmp(n_start, 0);
		cmp(n_pace, 1);
		cmp(n_conv, 2);
		cmp(acq_active, 1'b0);
		chk(aqe_pkg::OFF_STATUS, 32'h28);
		chk(aqe_pkg::OFF_SCOUNT, 32'h0);
		cmp(hresp, 1'b0);
		finish_test();
	end
endmodule // adc_acquisition_timing_engine_tb
`default_nettype wire
